/* smcu_device.sv */
`timescale 1ns/1ps
module smcu_device #(
    parameter int QUAL_LONG   = smcu_pkg::QUAL_LONG_CYC,
    parameter int QUAL_SHORT  = smcu_pkg::QUAL_SHORT_CYC,
    parameter int COPY_CYCLES = smcu_pkg::COPY_CYC,
    parameter int MEM_BYTES   = smcu_pkg::SRAM_BYTES
) (
    input  wire logic        CLK,        // 200 mhz clock
    input  wire logic        RESETN,     // async reset, active low
    smcu_link_if.device      LINK,       // serial line to the master
    input  wire logic [2:0]  ALARM,      // alarm matches from the counters
    output logic             OSC_RUN,    // oscillator enable
    output logic             TIMER_AUTO, // interval timer automatic mode
    output logic             TIMER_RUN,  // interval timer counting
    output logic             LINE_QUAL,  // qualified line level
    output logic             EXPIRED     // programmable expiration seen
);
    localparam int AW = $clog2(MEM_BYTES);

    smcu_pkg::smcu_dev_state_e state, next_state;
    logic [7:0]  rx, tx, next_tx, cmd, es, ctrl;
    logic [2:0]  bitcnt;
    logic [1:0]  bytecnt, copy_run;
    logic [4:0]  ptr, copy_idx;
    logic        past, auth_ok, copy_done, next_pull;
    logic [15:0] ta, rd_addr, rd_addr_inc, copy_a, copy_cnt;
    logic [7:0]  sp [0:31];
    logic [7:0]  mem [0:MEM_BYTES-1];
    logic [2:0]  alarm_s1, alarm_s2;
    logic [31:0] qcnt;
    logic        byte_done, sending, acc_full, acc_read, copy_start, auth_end, copy_we;
    logic [7:0]  byte_in, copy_d;

    // byte-level decode of the bit stream
    assign byte_in     = {LINK.slot_bit, rx[7:1]};
    assign byte_done   = LINK.slot && (bitcnt == 3'h7);
    assign sending     = (state == smcu_pkg::S_RSP) || (state == smcu_pkg::S_RMEM);
    assign acc_full    = !EXPIRED;
    assign acc_read    = !EXPIRED || ctrl[smcu_pkg::CB_RO];
    assign auth_end    = (state == smcu_pkg::S_AUTH) && byte_done && (bytecnt == 2'h2);
    assign copy_start  = auth_end && auth_ok && (byte_in == es);
    assign rd_addr_inc = (rd_addr == 16'hffff) ? rd_addr : rd_addr + 16'h0001;
    assign copy_we     = (state == smcu_pkg::S_COPY) && !copy_done;
    assign copy_a      = {ta[15:5], copy_idx};
    assign copy_d      = sp[copy_idx];

    // memory byte as seen by a read
    function automatic logic [7:0] mem_rd(input logic [15:0] a);
        if (a < 16'(MEM_BYTES))
            return mem[a[AW-1:0]];
        else if (a == smcu_pkg::CTRL_ADDR)
            return ctrl;
        else if (a <= smcu_pkg::MEM_LAST)
            return 8'h00;
        return 8'hff;
    endfunction

    // command sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            smcu_pkg::S_IDLE: if (LINK.rom_done) next_state = smcu_pkg::S_CMD;
            smcu_pkg::S_CMD: if (byte_done) begin
                case (byte_in)
                    smcu_pkg::CMD_WRITE_SP: next_state = acc_full ? smcu_pkg::S_ADDR : smcu_pkg::S_ONES;
                    smcu_pkg::CMD_COPY_SP:  next_state = acc_full ? smcu_pkg::S_AUTH : smcu_pkg::S_ONES;
                    smcu_pkg::CMD_READ_SP:  next_state = acc_read ? smcu_pkg::S_RSP : smcu_pkg::S_ONES;
                    smcu_pkg::CMD_READ_MEM: next_state = acc_read ? smcu_pkg::S_ADDR : smcu_pkg::S_ONES;
                    default:                next_state = smcu_pkg::S_ONES;
                endcase
            end
            smcu_pkg::S_ADDR: if (byte_done && bytecnt == 2'h1) begin
                next_state = (cmd == smcu_pkg::CMD_WRITE_SP) ? smcu_pkg::S_WDATA : smcu_pkg::S_RMEM;
            end
            smcu_pkg::S_AUTH: if (auth_end) next_state = copy_start ? smcu_pkg::S_COPY : smcu_pkg::S_ONES;
            smcu_pkg::S_COPY: if (copy_cnt == 16'(COPY_CYCLES - 1)) next_state = smcu_pkg::S_ZERO;
            smcu_pkg::S_WDATA, smcu_pkg::S_RSP, smcu_pkg::S_RMEM,
            smcu_pkg::S_ZERO, smcu_pkg::S_ONES: next_state = state;
            default: next_state = smcu_pkg::S_IDLE;
        endcase
        if (LINK.bus_reset && state != smcu_pkg::S_COPY) next_state = smcu_pkg::S_IDLE;
    end

    // next byte to shift out, lsb first
    always_comb begin
        next_tx = tx;
        if (LINK.slot && sending) next_tx = {1'b1, tx[7:1]};
        if (state == smcu_pkg::S_CMD && byte_done && next_state == smcu_pkg::S_RSP) next_tx = ta[7:0];
        if (state == smcu_pkg::S_RSP && byte_done) begin
            if (bytecnt == 2'h0)      next_tx = ta[15:8];
            else if (bytecnt == 2'h1) next_tx = es;
            else                      next_tx = past ? 8'hff : sp[ptr];
        end
        if (state == smcu_pkg::S_ADDR && byte_done && next_state == smcu_pkg::S_RMEM)
            next_tx = mem_rd({byte_in, ta[7:0]});
        if (state == smcu_pkg::S_RMEM && byte_done) next_tx = mem_rd(rd_addr_inc);
        if (next_state == smcu_pkg::S_RSP || next_state == smcu_pkg::S_RMEM)
            next_pull = ~next_tx[0];
        else
            next_pull = (next_state == smcu_pkg::S_ZERO);
    end

    // state, bit engine and line drive
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state             <= smcu_pkg::S_IDLE;
            rx                <= 8'h00;
            tx                <= 8'hff;
            bitcnt            <= 3'h0;
            LINK.dev_pull_low <= 1'b0;
        end else begin
            state             <= next_state;
            tx                <= next_tx;
            LINK.dev_pull_low <= next_pull;
            if (LINK.slot) rx <= byte_in;
            if (next_state == smcu_pkg::S_IDLE || next_state == smcu_pkg::S_COPY) bitcnt <= 3'h0;
            else if (LINK.slot) bitcnt <= bitcnt + 3'h1;
        end
    end

    // address, status and scratchpad pointer
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ta <= smcu_pkg::TA_RST;
            es <= smcu_pkg::ES_RST;
            cmd <= 8'h00;
            bytecnt <= 2'h0;
            ptr <= 5'h00;
            past <= 1'b0;
            auth_ok <= 1'b0;
            rd_addr <= 16'h0000;
        end else begin
            if (state == smcu_pkg::S_CMD) bytecnt <= 2'h0;
            else if (byte_done && bytecnt != 2'h3) bytecnt <= bytecnt + 2'h1;
            if (state == smcu_pkg::S_CMD && byte_done) begin
                cmd <= byte_in;
                ptr <= ta[4:0];
                past <= 1'b0;
                if (byte_in == smcu_pkg::CMD_WRITE_SP && acc_full) begin
                    es[smcu_pkg::ES_OF] <= 1'b0;
                    es[smcu_pkg::ES_PF] <= 1'b0;
                    es[smcu_pkg::ES_AA] <= 1'b0;
                end
            end
            if (state == smcu_pkg::S_ADDR && byte_done) begin
                if (bytecnt == 2'h0) begin
                    ta[7:0] <= byte_in;
                    ptr <= byte_in[4:0];
                end else begin
                    ta[15:8] <= byte_in;
                    rd_addr <= {byte_in, ta[7:0]};
                end
            end
            if (state == smcu_pkg::S_RMEM && byte_done) rd_addr <= rd_addr_inc;
            if (state == smcu_pkg::S_WDATA && LINK.slot && past) es[smcu_pkg::ES_OF] <= 1'b1;
            if ((state == smcu_pkg::S_WDATA || (state == smcu_pkg::S_RSP && bytecnt >= 2'h2))
                && byte_done && !past) begin
                if (state == smcu_pkg::S_WDATA) es[smcu_pkg::ES_OFS_MSB:0] <= ptr;
                if (ptr == smcu_pkg::PAGE_LAST) past <= 1'b1;
                else ptr <= ptr + 5'h01;
            end
            if (state == smcu_pkg::S_WDATA && LINK.bus_reset && bitcnt != 3'h0
                && !past && !es[smcu_pkg::ES_OF]) begin
                es[smcu_pkg::ES_PF] <= 1'b1;
                es[smcu_pkg::ES_OFS_MSB:0] <= ptr;
            end
            if (state == smcu_pkg::S_AUTH && byte_done) begin
                unique case (bytecnt)
                    2'h0: auth_ok <= (byte_in == ta[7:0]);
                    2'h1: auth_ok <= auth_ok && (byte_in == ta[15:8]);
                    default: auth_ok <= auth_ok;
                endcase
            end
            if (copy_start) es[smcu_pkg::ES_AA] <= 1'b1;
        end
    end

    // scratchpad storage, partial byte right aligned
    always_ff @(posedge CLK) begin
        if (state == smcu_pkg::S_WDATA && byte_done && !past) sp[ptr] <= byte_in;
        if (state == smcu_pkg::S_WDATA && LINK.bus_reset && bitcnt != 3'h0 && !past)
            sp[ptr] <= rx >> (3'h0 - bitcnt);
    end

    // copy progress and run of successful copies
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            copy_cnt  <= 16'h0000;
            copy_idx  <= 5'h00;
            copy_done <= 1'b0;
            copy_run  <= 2'h0;
        end else begin
            if (copy_start) begin
                copy_cnt  <= 16'h0000;
                copy_idx  <= ta[4:0];
                copy_done <= 1'b0;
                if (copy_run != 2'h3) copy_run <= copy_run + 2'h1;
            end else if (state == smcu_pkg::S_COPY) begin
                copy_cnt <= copy_cnt + 16'h0001;
                if (!copy_done) begin
                    if (copy_idx == es[smcu_pkg::ES_OFS_MSB:0]) copy_done <= 1'b1;
                    else copy_idx <= copy_idx + 5'h01;
                end
            end
            if ((state == smcu_pkg::S_CMD && byte_done && byte_in != smcu_pkg::CMD_COPY_SP)
                || (auth_end && !copy_start))
                copy_run <= 2'h0;
        end
    end

    // main memory written by copy
    always_ff @(posedge CLK) begin
        if (copy_we && copy_a < 16'(MEM_BYTES)) mem[copy_a[AW-1:0]] <= copy_d;
    end

    // control byte with its locks
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= smcu_pkg::CTRL_RST;
        end else if (copy_we && copy_a == smcu_pkg::CTRL_ADDR) begin
            if (copy_run == smcu_pkg::COPIES_FOR_LOCK && ctrl[2:0] == 3'h0)
                ctrl[2:0] <= copy_d[2:0];
            if (ctrl[2:0] == 3'h0) begin
                ctrl[smcu_pkg::CB_RO]  <= copy_d[smcu_pkg::CB_RO];
                ctrl[smcu_pkg::CB_OSC] <= copy_d[smcu_pkg::CB_OSC];
            end else begin
                ctrl[smcu_pkg::CB_OSC] <= ctrl[smcu_pkg::CB_OSC] | copy_d[smcu_pkg::CB_OSC];
            end
            ctrl[smcu_pkg::CB_AUTO] <= copy_d[smcu_pkg::CB_AUTO];
            ctrl[smcu_pkg::CB_HALT] <= ctrl[smcu_pkg::CB_INTVL_LOCK] ? 1'b0 : copy_d[smcu_pkg::CB_HALT];
            if (!ctrl[smcu_pkg::CB_CYCLE_LOCK]) ctrl[smcu_pkg::CB_TRANSITION_DELAY_SELECT] <= copy_d[smcu_pkg::CB_TRANSITION_DELAY_SELECT];
        end
    end

    // alarm sync and sticky expiration
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            alarm_s1 <= 3'h0;
            alarm_s2 <= 3'h0;
            EXPIRED  <= 1'b0;
        end else begin
            alarm_s1 <= ALARM;
            alarm_s2 <= alarm_s1;
            if ((alarm_s2 & ctrl[2:0]) != 3'h0) EXPIRED <= 1'b1;
        end
    end

    // line transition qualifier and timer controls
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            qcnt       <= 32'h0;
            LINE_QUAL  <= 1'b1;
            OSC_RUN    <= 1'b0;
            TIMER_AUTO <= 1'b0;
            TIMER_RUN  <= 1'b0;
        end else begin
            if (LINK.dq == LINE_QUAL) begin
                qcnt <= 32'h0;
            end else if (qcnt >= 32'(ctrl[smcu_pkg::CB_TRANSITION_DELAY_SELECT] ? QUAL_LONG - 1 : QUAL_SHORT - 1)) begin
                qcnt      <= 32'h0;
                LINE_QUAL <= LINK.dq;
            end else begin
                qcnt <= qcnt + 32'h1;
            end
            OSC_RUN    <= ctrl[smcu_pkg::CB_OSC];
            TIMER_AUTO <= ctrl[smcu_pkg::CB_AUTO];
            TIMER_RUN  <= ctrl[smcu_pkg::CB_OSC] &&
                          (ctrl[smcu_pkg::CB_AUTO] ? LINE_QUAL : !ctrl[smcu_pkg::CB_HALT]);
        end
    end
endmodule // smcu_device

/* smcu_pkg.sv */
package smcu_pkg;
    // clock rate
    localparam int CLK_MHZ = 200;

    // memory function command codes
    localparam logic [7:0] CMD_WRITE_SP = 8'h0f;
    localparam logic [7:0] CMD_READ_SP  = 8'haa;
    localparam logic [7:0] CMD_COPY_SP  = 8'h55;
    localparam logic [7:0] CMD_READ_MEM = 8'hf0;

    // ending offset / status byte fields
    localparam int ES_OFS_MSB = 4;
    localparam int ES_PF      = 5;
    localparam int ES_OF      = 6;
    localparam int ES_AA      = 7;
    localparam logic [7:0] ES_RST = 8'h00;

    // timekeeping control byte fields
    localparam int CB_CLOCK_LOCK = 0;
    localparam int CB_INTVL_LOCK = 1;
    localparam int CB_CYCLE_LOCK = 2;
    localparam int CB_RO         = 3;
    localparam int CB_OSC        = 4;
    localparam int CB_AUTO       = 5;
    localparam int CB_HALT       = 6;
    localparam int CB_TRANSITION_DELAY_SELECT       = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // address map
    localparam logic [15:0] TA_RST     = 16'h0000;
    localparam logic [15:0] CTRL_ADDR  = 16'h0201;
    localparam logic [15:0] MEM_LAST   = 16'h021d;
    localparam int          SRAM_BYTES = 512;
    localparam logic [4:0]  PAGE_LAST  = 5'h1f;

    // line qualification delays and copy time
    localparam int  QUAL_LONG_MS   = 123;
    localparam real QUAL_SHORT_MS  = 3.5;
    localparam int  QUAL_LONG_CYC  = QUAL_LONG_MS * CLK_MHZ * 1000;
    localparam int  QUAL_SHORT_CYC = int'(QUAL_SHORT_MS * CLK_MHZ * 1000.0);
    localparam int  COPY_US        = 30;
    localparam int  COPY_CYC       = COPY_US * CLK_MHZ;
    localparam logic [1:0] COPIES_FOR_LOCK = 2'h3;

    // controller register port
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STAT   = 8'h04;
    localparam int         CMD_OP_LSB = 8;
    localparam int         ST_BUSY    = 8;
    localparam logic [1:0] OP_RESET   = 2'h1;
    localparam logic [1:0] OP_WRITE   = 2'h2;
    localparam logic [1:0] OP_READ    = 2'h3;
    localparam int         SLOT_GAP   = 4;
    localparam int         RESET_CYC  = 4;

    // device states, gray along idle-cmd-addr-data
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_CMD   = 4'h1,
        S_ADDR  = 4'h3,
        S_WDATA = 4'h2,
        S_RSP   = 4'h6,
        S_RMEM  = 4'h7,
        S_AUTH  = 4'h5,
        S_COPY  = 4'h4,
        S_ZERO  = 4'hc,
        S_ONES  = 4'hd
    } smcu_dev_state_e;

    // controller states
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_RST  = 2'h1,
        M_SEL  = 2'h3,
        M_BITS = 2'h2
    } smcu_mst_state_e;
endpackage

/* smcu_link_if.sv */
`timescale 1ns/1ps
interface smcu_link_if;
    logic bus_reset;    // master holds line low for a bus reset
    logic rom_done;     // rom selection finished, one cycle
    logic slot;         // one time slot, one cycle
    logic slot_bit;     // bit written in the slot, 1 for a read slot
    logic dev_pull_low; // device holds the line low in slots
    logic dq;           // resolved wired-and line level

    // open-drain resolution of the single line
    assign dq = ~(bus_reset | (slot & (~slot_bit | dev_pull_low)));

    modport master (output bus_reset, output rom_done, output slot, output slot_bit,
                    input dev_pull_low, input dq);
    modport device (input bus_reset, input rom_done, input slot, input slot_bit,
                    output dev_pull_low, input dq);
endinterface

/* smcu_master.sv */
`timescale 1ns/1ps
module smcu_master #(
    parameter int GAP       = smcu_pkg::SLOT_GAP,
    parameter int RST_CYCLES = smcu_pkg::RESET_CYC
) (
    input  wire logic        CLK,    // 200 mhz clock
    input  wire logic        RESETN, // async reset, active low
    smcu_link_if.master      LINK,   // serial line to the device
    input  wire logic [7:0]  ADDR,   // register byte address
    input  wire logic [31:0] WDATA,  // write data
    input  wire logic        WR,     // write strobe
    input  wire logic        RD,     // read strobe
    output logic [31:0]      RDATA   // read data, cycle after rd
);
    smcu_pkg::smcu_mst_state_e state;
    logic [7:0] shreg, rxbyte, rxsh;
    logic [2:0] bitcnt;
    logic [7:0] cnt;
    logic       busy, start;
    logic [1:0] op;

    assign op    = WDATA[smcu_pkg::CMD_OP_LSB +: 2];
    assign start = WR && (ADDR == smcu_pkg::REG_CMD) && !busy && (op != 2'h0);
    assign busy  = (state != smcu_pkg::M_IDLE);

    // line sequencer: reset, rom handoff, bit slots
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state          <= smcu_pkg::M_IDLE;
            shreg          <= 8'hff;
            rxsh           <= 8'h00;
            rxbyte         <= 8'h00;
            bitcnt         <= 3'h0;
            cnt            <= 8'h00;
            LINK.bus_reset <= 1'b0;
            LINK.rom_done  <= 1'b0;
            LINK.slot      <= 1'b0;
            LINK.slot_bit  <= 1'b1;
        end else begin
            LINK.rom_done <= 1'b0;
            LINK.slot     <= 1'b0;
            unique case (state)
                smcu_pkg::M_IDLE: if (start) begin
                    cnt    <= 8'h00;
                    bitcnt <= 3'h0;
                    if (op == smcu_pkg::OP_RESET) begin
                        state          <= smcu_pkg::M_RST;
                        LINK.bus_reset <= 1'b1;
                    end else begin
                        state <= smcu_pkg::M_BITS;
                        shreg <= (op == smcu_pkg::OP_WRITE) ? WDATA[7:0] : 8'hff;
                    end
                end
                smcu_pkg::M_RST: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(RST_CYCLES - 1)) begin
                        LINK.bus_reset <= 1'b0;
                        state          <= smcu_pkg::M_SEL;
                    end
                end
                smcu_pkg::M_SEL: begin
                    LINK.rom_done <= 1'b1;
                    state         <= smcu_pkg::M_IDLE;
                end
                smcu_pkg::M_BITS: begin
                    if (LINK.slot) begin
                        rxsh  <= {LINK.dq, rxsh[7:1]};
                        shreg <= {1'b1, shreg[7:1]};
                        bitcnt <= bitcnt + 3'h1;
                        if (bitcnt == 3'h7) begin
                            rxbyte <= {LINK.dq, rxsh[7:1]};
                            state  <= smcu_pkg::M_IDLE;
                        end
                    end
                    if (cnt == 8'(GAP - 1)) begin
                        cnt           <= 8'h00;
                        LINK.slot     <= 1'b1;
                        LINK.slot_bit <= shreg[0];
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                default: state <= smcu_pkg::M_IDLE;
            endcase
        end
    end

    // register read port
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 32'h0;
        end else if (RD && ADDR == smcu_pkg::REG_STAT) begin
            RDATA <= 32'({busy, rxbyte});
        end else begin
            RDATA <= 32'h0;
        end
    end
endmodule // smcu_master

/* smcu_link_props.sv */
`timescale 1ns/1ps
module smcu_link_props (
    input wire logic CLK,          // clock
    input wire logic RESETN,       // async reset, active low
    input wire logic bus_reset,    // line held low
    input wire logic rom_done,     // selection finished
    input wire logic slot,         // one time slot
    input wire logic slot_bit,     // bit of the slot
    input wire logic dev_pull_low, // device pulls low
    input wire logic dq            // resolved line
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // bus reset is four cycles low, then released
    sequence rst_pulse;
        bus_reset [*4] ##1 !bus_reset;
    endsequence
    // line level, reset framing and slot spacing
    chk_line_level: assert property (dq == ~(bus_reset | slot & (~slot_bit | dev_pull_low)))
        else $error("line level wrong");
    chk_reset_len: assert property ($rose(bus_reset) |-> rst_pulse)
        else $error("bus reset length wrong");
    chk_rom_after: assert property (rom_done |-> !bus_reset && $past(bus_reset, 2))
        else $error("selection not right after reset");
    chk_rom_pulse: assert property (rom_done |=> !rom_done)
        else $error("selection pulse too long");
    chk_slot_gap: assert property (slot |=> !slot [*3])
        else $error("slots too close");
    chk_slot_quiet: assert property (bus_reset |-> !slot && !rom_done)
        else $error("slot during bus reset");
    chk_pull_hold: assert property (slot |-> $stable(dev_pull_low))
        else $error("device bit moved inside slot");
    chk_pull_release: assert property ($fell(bus_reset) |-> !dev_pull_low ##1 !dev_pull_low)
        else $error("device still pulls after reset");
endmodule // smcu_link_props

/* scratchpad_memory_command_unit_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("Error at %0t: got %h exp %h", $time, a, e); end end
module scratchpad_memory_command_unit_test;
    logic        clk, resetn, wr, rd, osc, auto, run, qual, expd;
    logic [7:0]  addr, r, cb;
    logic [2:0]  alarm;
    logic [31:0] wdata, rdata;
    logic [7:0]  sp [32];
    logic [7:0]  ctl [3] = '{8'h10, 8'h50, 8'h30};
    int          seed = 7895, mismatches = 0, num_checks = 0;
    smcu_link_if link ();
    smcu_master i_smcu_master (.CLK(clk), .RESETN(resetn), .LINK(link.master), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    smcu_device #(.QUAL_LONG(40), .QUAL_SHORT(10), .COPY_CYCLES(20)) i_smcu_device (.CLK(clk), .RESETN(resetn),
        .LINK(link.device), .ALARM(alarm), .OSC_RUN(osc), .TIMER_AUTO(auto), .TIMER_RUN(run), .LINE_QUAL(qual),
        .EXPIRED(expd));
    smcu_link_props i_smcu_link_props (.CLK(clk), .RESETN(resetn), .bus_reset(link.bus_reset),
        .rom_done(link.rom_done), .slot(link.slot), .slot_bit(link.slot_bit), .dev_pull_low(link.dev_pull_low),
        .dq(link.dq));
    // one controller command, then poll busy; r keeps the last byte
    task automatic op(input logic [1:0] c, input logic [7:0] b);
        int n;
        logic [8:0] s;
        n = 0;
        @(posedge clk);
        addr <= smcu_pkg::REG_CMD;
        wdata <= {22'h0, c, b};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= smcu_pkg::REG_STAT;
        do begin
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 s = rdata[8:0];
            n++;
            @(posedge clk);
        end while (s[8] !== 1'b0 && n < 100);
        r = s[7:0];
        if (n == 100) mismatches++;
    endtask
    task automatic tx(input logic [7:0] b);
        op(smcu_pkg::OP_WRITE, b);
    endtask
    task automatic rx(input logic [7:0] e);
        op(smcu_pkg::OP_READ, 8'h00);
        `CHK(r, e)
    endtask
    // bus reset with selection, then the command byte
    task automatic start(input logic [7:0] c);
        op(smcu_pkg::OP_RESET, 8'h00);
        tx(c);
    endtask
    task automatic addr_out(input logic [7:0] c, input logic [15:0] ta);
        start(c);
        tx(ta[7:0]);
        tx(ta[15:8]);
    endtask
    task automatic wsp(input logic [15:0] ta, input int k);
        addr_out(smcu_pkg::CMD_WRITE_SP, ta);
        for (int i = 0; i < k; i++) tx(sp[5'(ta[4:0] + i)]);
    endtask
    task automatic rsp(input logic [15:0] ta, input logic [7:0] es);
        start(smcu_pkg::CMD_READ_SP);
        rx(ta[7:0]);
        rx(ta[15:8]);
        rx(es);
        for (int i = ta[4:0]; i <= es[4:0]; i++) rx(sp[i]);
        if (es[4:0] == 5'h1f) rx(8'hff);
    endtask
    task automatic cpy(input logic [15:0] ta, input logic [7:0] es);
        addr_out(smcu_pkg::CMD_COPY_SP, ta);
        tx(es);
        repeat (40) @(posedge clk);
        rx(8'h00);
    endtask
    task automatic rmem(input logic [15:0] ta, input int k);
        addr_out(smcu_pkg::CMD_READ_MEM, ta);
        for (int i = 0; i < k; i++) rx(sp[5'(ta[4:0] + i)]);
    endtask
    // expected status byte after a scratchpad write of k bytes
    function automatic logic [7:0] es_of(input logic [4:0] o, input int k);
        return (o + k > 32) ? 8'h5f : {3'h0, 5'(o + k - 1)};
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        final_report();
    end
    // main sequence
    initial begin
        logic [15:0] ta;
        logic [7:0] es;
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        alarm = 3'h0;
        for (int i = 0; i < 32; i++) sp[i] = 8'($random(seed));
        ta = {11'h003, 1'b0, 4'($random(seed))};
        es = es_of(ta[4:0], 3);
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wsp(ta, 3);
        rsp(ta, es);
        $display("scratchpad round trip done");
        cpy(ta, es);
        rsp(ta, es | 8'h80);
        rmem(ta + 16'h1, 2);
        rsp(ta + 16'h1, es | 8'h80);
        $display("copy and memory read done");
        wsp({ta[15:5], 5'h1e}, 3);
        rsp({ta[15:5], 5'h1e}, 8'h5f);
        addr_out(smcu_pkg::CMD_COPY_SP, {ta[15:5], 5'h1e} ^ 16'h1);
        tx(8'h5f);
        rx(8'hff);
        $display("overflow and bad authorization done");
        foreach (ctl[j]) begin
            cb = ctl[j];
            sp[1] = cb;
            wsp(smcu_pkg::CTRL_ADDR, 1);
            cpy(smcu_pkg::CTRL_ADDR, 8'h01);
            rmem(smcu_pkg::CTRL_ADDR, 1);
            `CHK(osc, cb[4])
            `CHK(auto, cb[5])
            `CHK(run, cb[4] & (cb[5] | ~cb[6]))
        end
        $display("control modes done");
        // three copies in a row set the clock lock with read-only and oscillator
        sp[1] = 8'h19;
        wsp(smcu_pkg::CTRL_ADDR, 1);
        cpy(smcu_pkg::CTRL_ADDR, 8'h01);
        repeat (2) cpy(smcu_pkg::CTRL_ADDR, 8'h81);
        rmem(smcu_pkg::CTRL_ADDR, 1);
        // alarm of an unlocked counter does not expire, a locked one does
        alarm <= 3'h2;
        repeat (4) @(posedge clk);
        `CHK(expd, 1'b0)
        alarm <= 3'h1;
        repeat (4) @(posedge clk);
        `CHK(expd, 1'b1)
        start(smcu_pkg::CMD_WRITE_SP);
        rx(8'hff);
        start(smcu_pkg::CMD_READ_SP);
        rx(8'h01);
        $display("lock and expiry done");
        final_report();
    end
endmodule // scratchpad_memory_command_unit_test
